//--- verilog/adc_readout_pkg.sv
`default_nettype none
package adc_readout_pkg;
    // ==========================================================
    // Word and field sizes
    localparam int RESULT_W    = 32;
    localparam int BYTE_W      = 8;
    localparam int MUX_ADDR_W  = 4;
    localparam int SYNC_DEPTH  = 2;
    localparam int PIN_COUNT   = 4;
    localparam int BIT_CNT_W   = $clog2(RESULT_W);
    localparam int EOC_BIT     = RESULT_W - 1;

    // ==========================================================
    // Reset values
    localparam logic [MUX_ADDR_W-1:0] CHANNEL_RST = 4'h0;
    localparam logic                  SDO_RST     = 1'b1;

    // ==========================================================
    // Pin groups
    typedef struct packed {
        logic sclk;
        logic sdi;
        logic converter_chip_select_n;
        logic mux_chip_select_n;
    } link_in_t;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } link_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_EOC,
        ST_SHIFT,
        ST_DONE
    } readout_state_t;
endpackage
`default_nettype wire

//--- verilog/pin_sync.sv
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = ce ? async_in : meta_r;
        sync_nxt = ce ? meta_r : sync_out;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end
endmodule
`default_nettype wire

//--- verilog/adc_mux_serial_readout.sv
`default_nettype none
module adc_mux_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int RES_W  = RESULT_W,
    parameter int ADDR_W = MUX_ADDR_W
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    input  wire adc_readout_pkg::link_in_t pins_in,
    input  wire logic                     result_valid,
    input  wire logic [RES_W-1:0]         result_data,
    output var adc_readout_pkg::link_out_t pins_out_r,
    output logic [ADDR_W-1:0]             channel_r,
    output logic                          conv_start_r
);
    import adc_readout_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pins_s;
    logic                 sclk_s;
    logic                 sdi_s;
    logic                 cs_active;

    // Selects enter inverted so the synchroniser's reset value is the idle level
    assign pins_raw = {pins_in.sclk, pins_in.sdi,
                       ~pins_in.converter_chip_select_n, ~pins_in.mux_chip_select_n};

    pin_sync #(
        .W (PIN_COUNT)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign sclk_s    = pins_s[3];
    assign sdi_s     = pins_s[2];
    // Both selects are tied; interface is live only with both low
    assign cs_active = pins_s[1] && pins_s[0];

    // ==========================================================
    // Edge detection
    logic sclk_q_r;
    logic cs_q_r;
    logic sclk_q_nxt;
    logic cs_q_nxt;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    assign sclk_rise = sclk_s && !sclk_q_r;
    assign sclk_fall = !sclk_s && sclk_q_r;
    assign cs_fall   = cs_active && !cs_q_r;
    assign cs_rise   = !cs_active && cs_q_r;

    always_comb begin
        sclk_q_nxt = ce ? sclk_s : sclk_q_r;
        cs_q_nxt   = ce ? cs_active : cs_q_r;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q_r <= 1'b0;
            cs_q_r   <= 1'b0;
        end else begin
            sclk_q_r <= sclk_q_nxt;
            cs_q_r   <= cs_q_nxt;
        end
    end

    // ==========================================================
    // Channel address and conversion control
    logic [ADDR_W-1:0] mux_sr_r;
    logic [ADDR_W-1:0] mux_sr_nxt;
    logic [ADDR_W-1:0] channel_nxt;
    logic              conv_start_nxt;
    logic              have_r;
    logic              have_nxt;
    logic [RES_W-1:0]  result_r;
    logic [RES_W-1:0]  result_nxt;

    always_comb begin
        mux_sr_nxt     = mux_sr_r;
        channel_nxt    = channel_r;
        conv_start_nxt = 1'b0;
        have_nxt       = have_r;
        result_nxt     = result_r;
        if (ce) begin
            // Address bits shift in while the interface is idle
            if (!cs_active && sclk_rise) begin
                mux_sr_nxt = {mux_sr_r[ADDR_W-2:0], sdi_s};
            end
            if (cs_fall) begin
                channel_nxt = mux_sr_r;
            end
            conv_start_nxt = cs_rise;
            // A result arriving with the restart is kept: set wins
            if (result_valid) begin
                have_nxt   = 1'b1;
                result_nxt = result_data;
            end else if (cs_rise) begin
                have_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mux_sr_r     <= ADDR_W'(CHANNEL_RST);
            channel_r    <= ADDR_W'(CHANNEL_RST);
            conv_start_r <= 1'b0;
            have_r       <= 1'b0;
            result_r     <= '0;
        end else begin
            mux_sr_r     <= mux_sr_nxt;
            channel_r    <= channel_nxt;
            conv_start_r <= conv_start_nxt;
            have_r       <= have_nxt;
            result_r     <= result_nxt;
        end
    end

    // ==========================================================
    // Serial readout
    readout_state_t       state_r;
    readout_state_t       state_nxt;
    logic [RES_W-1:0]     sr_r;
    logic [RES_W-1:0]     sr_nxt;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [BIT_CNT_W-1:0] bit_cnt_nxt;
    link_out_t            pins_out_nxt;

    always_comb begin
        state_nxt   = state_r;
        sr_nxt      = sr_r;
        bit_cnt_nxt = bit_cnt_r;
        if (ce) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_nxt = ST_WAIT_EOC;
                    end
                end
                ST_WAIT_EOC: begin
                    if (!cs_active) begin
                        state_nxt = ST_IDLE;
                    end else if (have_r) begin
                        // Leading bit is the end-of-conversion flag, low
                        state_nxt   = ST_SHIFT;
                        sr_nxt      = {1'b0, result_r[RES_W-2:0]};
                        bit_cnt_nxt = '0;
                    end
                end
                ST_SHIFT: begin
                    if (!cs_active) begin
                        state_nxt = ST_IDLE;
                    end else if (sclk_fall) begin
                        if (bit_cnt_r == BIT_CNT_W'(RES_W - 1)) begin
                            state_nxt = ST_DONE;
                        end else begin
                            sr_nxt      = {sr_r[RES_W-2:0], 1'b0};
                            bit_cnt_nxt = bit_cnt_r + 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    if (!cs_active) begin
                        state_nxt = ST_IDLE;
                    end
                end
            endcase
        end
        pins_out_nxt.sdo_oe = (state_nxt != ST_IDLE);
        pins_out_nxt.sdo    = (state_nxt == ST_WAIT_EOC || state_nxt == ST_IDLE)
                            ? SDO_RST : sr_nxt[RES_W-1];
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= ST_IDLE;
            sr_r       <= '0;
            bit_cnt_r  <= '0;
            pins_out_r <= '{sdo: SDO_RST, sdo_oe: 1'b0};
        end else begin
            state_r    <= state_nxt;
            sr_r       <= sr_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            pins_out_r <= pins_out_nxt;
        end
    end

    // ==========================================================
    // Checks
    sequence s_eoc_seen;
        ce && state_r == ST_WAIT_EOC && cs_active && have_r;
    endsequence

    property p_enable;
        @(posedge clock) disable iff (sys_rst)
        ce && cs_fall |=> pins_out_r.sdo_oe;
    endproperty
    a_enable: assert property (p_enable) else $error("select low did not enable output");

    property p_channel;
        @(posedge clock) disable iff (sys_rst)
        ce && cs_fall |=> channel_r == $past(mux_sr_r);
    endproperty
    a_channel: assert property (p_channel) else $error("loaded channel not connected");

    property p_busy_high;
        @(posedge clock) disable iff (sys_rst)
        state_r == ST_WAIT_EOC |-> pins_out_r.sdo && pins_out_r.sdo_oe;
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("output not high before end");

    property p_eoc_low;
        @(posedge clock) disable iff (sys_rst)
        s_eoc_seen |=> !pins_out_r.sdo && state_r == ST_SHIFT;
    endproperty
    a_eoc_low: assert property (p_eoc_low) else $error("end of conversion not driven low");

    property p_word_len;
        @(posedge clock) disable iff (sys_rst)
        s_eoc_seen |=> bit_cnt_r == '0;
    endproperty
    a_word_len: assert property (p_word_len) else $error("bit count not cleared at word start");

    property p_word_end;
        @(posedge clock) disable iff (sys_rst)
        ce && state_r == ST_SHIFT && cs_active && sclk_fall
            && bit_cnt_r == BIT_CNT_W'(RES_W - 1) |=> state_r == ST_DONE;
    endproperty
    a_word_end: assert property (p_word_end) else $error("word did not end after 32 bits");

    property p_hiz;
        @(posedge clock) disable iff (sys_rst)
        ce && !cs_active |=> !pins_out_r.sdo_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while deselected");

    property p_start;
        @(posedge clock) disable iff (sys_rst)
        ce && cs_rise |=> conv_start_r ##1 (!conv_start_r || !$past(ce));
    endproperty
    a_start: assert property (p_start) else $error("no conversion start on select rise");
endmodule
`default_nettype wire

//--- bench/spi_host_model.sv
`default_nettype none
module spi_host_model (
    input  wire logic                      clock,
    input  wire adc_readout_pkg::link_out_t pins_out,
    output var adc_readout_pkg::link_in_t  pins_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_readout_pkg::*;

    logic line;

    // Released pin shows the inverse of its last value
    assign line = pins_out.sdo_oe ? pins_out.sdo : ~pins_out.sdo;

    initial pins_in = '{1'b0, 1'b0, 1'b1, 1'b1};

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ====
    // Host sequence
    task automatic send_addr(input logic [MUX_ADDR_W-1:0] a, input int h);
        for (int i = MUX_ADDR_W - 1; i >= 0; i--) begin
            pins_in.sdi <= a[i];
            tick(h);
            pins_in.sclk <= 1'b1;
            tick(h);
            pins_in.sclk <= 1'b0;
        end
        tick(h);
        pins_in.sdi <= ~a[0];
    endtask

    task automatic sel(input logic v);
        pins_in.converter_chip_select_n <= v;
        pins_in.mux_chip_select_n <= v;
    endtask

    task automatic wait_eoc(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++) begin
            tick(1);
            ok = (line === 1'b0);
        end
    endtask

    // Four byte transfers, most significant byte first
    task automatic read_word(output logic [RESULT_W-1:0] w, input int h);
        logic [BYTE_W-1:0] b;
        for (int k = RESULT_W / BYTE_W - 1; k >= 0; k--) begin
            for (int i = BYTE_W - 1; i >= 0; i--) begin
                tick(h);
                b[i] = line;
                pins_in.sclk <= 1'b1;
                tick(h);
                pins_in.sclk <= 1'b0;
            end
            w[k*BYTE_W +: BYTE_W] = b;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/adc_mux_serial_readout_tb.sv
`default_nettype none
module adc_mux_serial_readout_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_readout_pkg::*;

    logic                clock;
    logic                sys_rst;
    logic                ce;
    logic                result_valid;
    logic [RESULT_W-1:0] result_data;
    link_in_t            pins_in;
    link_out_t           pins_out_r;
    logic [3:0]          channel_r;
    logic                conv_start_r;
    int                  errors;
    int                  n_compared;
    int                  n_start;

    adc_mux_serial_readout dut (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .pins_in(pins_in),
        .result_valid(result_valid), .result_data(result_data),
        .pins_out_r(pins_out_r), .channel_r(channel_r), .conv_start_r(conv_start_r)
    );

    spi_host_model host (.clock(clock), .pins_out(pins_out_r), .pins_in(pins_in));

    always @(posedge clock) if (conv_start_r === 1'b1) n_start++;

    // ====
    // Compare and report
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // End-of-conversion flag replaces the top bit
    function automatic logic [31:0] expect_word(input logic [31:0] d);
        return {1'b0, d[30:0]};
    endfunction

    task automatic pulse(input logic [31:0] d);
        result_data <= d;
        result_valid <= 1'b1;
        @(posedge clock);
        result_valid <= 1'b0;
    endtask

    // ====
    // One measurement cycle; early stores the result before select
    // Stall drops the clock enable just after the result arrives, only when early is clear
    task automatic meas(input logic [3:0] a, input logic [31:0] d, input bit early,
                        input bit stall, input int h);
        logic [31:0] w;
        bit          ok;
        int          s;
        host.send_addr(a, h);
        if (early) pulse(d);
        host.sel(1'b0);
        repeat (5) @(posedge clock);
        chk_word("channel", 32'(a), 32'(channel_r));
        chk_bit("sdo_oe", 1'b1, pins_out_r.sdo_oe);
        if (!early) begin
            chk_bit("sdo_wait", 1'b1, pins_out_r.sdo);
            pulse(d);
            if (stall) begin
                ce <= 1'b0;
                repeat (4) @(posedge clock);
                chk_bit("sdo_frozen", 1'b1, pins_out_r.sdo);
                ce <= 1'b1;
            end
        end
        host.wait_eoc(ok);
        chk_bit("eoc", 1'b1, ok);
        if (!ok) print_verdict();
        host.read_word(w, h);
        chk_word("result", expect_word(d), w);
        repeat (h) @(posedge clock);
        s = n_start;
        host.sel(1'b1);
        repeat (5) @(posedge clock);
        chk_bit("sdo_off", 1'b0, pins_out_r.sdo_oe);
        chk_word("starts", 32'(s + 1), 32'(n_start));
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        result_valid = 1'b0;
        result_data = 32'h0;
        errors = 0;
        n_compared = 0;
        n_start = 0;
        void'($urandom(32'h5451));
        repeat (6) @(posedge clock);
        chk_bit("rst_oe", 1'b0, pins_out_r.sdo_oe);
        chk_bit("rst_sdo", 1'b1, pins_out_r.sdo);
        chk_word("rst_ch", 32'h0, 32'(channel_r));
        sys_rst <= 1'b0;
        @(posedge clock);
        meas(4'hF, 32'hFFFFFFFF, 1'b1, 1'b0, 4);
        meas(4'h0, 32'h00000000, 1'b0, 1'b1, 4);
        for (int i = 0; i < 6; i++) begin
            meas(4'($urandom), $urandom, 1'(i % 2), 1'(i % 3 == 0), 4);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
